//--- spcb_pkg.sv
// Purpose: Shared constants for the segmented packet client bus.
// Assumes: Four 128-bit segments per cycle, one client clock.
// Notes: Entry layout of the transmit buffer is {err,eop,sop,ena,data}.
`default_nettype none
package spcb_pkg;
	localparam int SEG_COUNT = 4;
	localparam int SEG_WIDTH = 128;
	localparam int MTY_WIDTH = 4;
	// Low empty-count bits forced to zero on an errored last transfer
	localparam int MTY_LOW_BITS = 3;
	localparam logic [MTY_LOW_BITS-1:0] MTY_ERR_LOW = 3'h0;
	// Transmit buffer entry layout
	localparam int DATA_BITS = SEG_COUNT * SEG_WIDTH;
	localparam int ENA_POS = DATA_BITS;
	localparam int SOP_POS = DATA_BITS + SEG_COUNT;
	localparam int EOP_POS = DATA_BITS + 2 * SEG_COUNT;
	localparam int ERR_POS = DATA_BITS + 3 * SEG_COUNT;
	localparam int ENTRY_WIDTH = DATA_BITS + 4 * SEG_COUNT;
	localparam int BUF_DEPTH = 16;
	localparam int BUF_ADDR_W = 4;
	localparam logic [4:0] BUF_FULL = 5'h10;
	// Ready stays high up to this fill; leaves room for the late window
	localparam logic [4:0] BUF_READY_MAX = 5'h08;
	// Cycles the user may keep sending after ready falls
	localparam logic [2:0] TX_RDY_WINDOW = 3'h4;
	// Error control code replacing a bad last word
	localparam logic [SEG_WIDTH-1:0] ERR_CTRL_WORD = {16{8'hFE}};
	typedef enum logic [1:0] {
		SPCB_IDLE = 2'b00,
		SPCB_PKT = 2'b01,
		SPCB_BAD = 2'b10
	} spcb_tx_state_type;
endpackage
`default_nettype wire

//--- spcb_buf_mem.sv
// Purpose: Small memory holding transmit words between client and MAC.
// Assumes: One write and one read port on the client clock.
// Notes: Read data comes out of a register, one cycle after the read.
`default_nettype none
module spcb_buf_mem
	import spcb_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic wr_en,
	input wire logic [BUF_ADDR_W-1:0] wr_addr,
	input wire logic [ENTRY_WIDTH-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [BUF_ADDR_W-1:0] rd_addr,
	output logic [ENTRY_WIDTH-1:0] rd_data
);
	logic [ENTRY_WIDTH-1:0] mem [BUF_DEPTH];

	// Storage has no reset; words are only read after being written
	always_ff @(posedge clk) begin
		if (clk_en && wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Registered read port
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= '0;
		end else if (clk_en && rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule
`default_nettype wire

//--- spcb_segmented_packet_client_bus.sv
// Purpose: Client side of the segmented_local_bus for a 100G MAC.
// Assumes: MAC datapath and user logic share clk; clk_en freezes all.
// Notes: Transmit words pass a 16-entry buffer to absorb the late window.
`default_nettype none
module spcb_segmented_packet_client_bus
	import spcb_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [SEG_COUNT-1:0][SEG_WIDTH-1:0] mac_rx_data,
	input wire logic [SEG_COUNT-1:0] mac_rx_ena,
	input wire logic [SEG_COUNT-1:0] mac_rx_sop,
	input wire logic [SEG_COUNT-1:0] mac_rx_eop,
	input wire logic [SEG_COUNT-1:0] mac_rx_err,
	input wire logic [SEG_COUNT-1:0][MTY_WIDTH-1:0] mac_rx_mty,
	output logic [SEG_COUNT-1:0][SEG_WIDTH-1:0] rx_data,
	output logic [SEG_COUNT-1:0] rx_ena,
	output logic [SEG_COUNT-1:0] rx_sop,
	output logic [SEG_COUNT-1:0] rx_eop,
	output logic [SEG_COUNT-1:0] rx_err,
	output logic [SEG_COUNT-1:0][MTY_WIDTH-1:0] rx_mty,
	input wire logic [SEG_COUNT-1:0][SEG_WIDTH-1:0] tx_data,
	input wire logic [SEG_COUNT-1:0] tx_ena,
	input wire logic [SEG_COUNT-1:0] tx_sop,
	input wire logic [SEG_COUNT-1:0] tx_eop,
	input wire logic [SEG_COUNT-1:0] tx_err,
	input wire logic tx_path_reset,
	output logic tx_rdy,
	output logic tx_ovf,
	output logic tx_unf,
	input wire logic mac_tx_accept,
	output logic [SEG_COUNT-1:0][SEG_WIDTH-1:0] mac_tx_data,
	output logic [SEG_COUNT-1:0] mac_tx_ena,
	output logic [SEG_COUNT-1:0] mac_tx_sop,
	output logic [SEG_COUNT-1:0] mac_tx_eop,
	output logic mac_tx_err_block,
	output logic mac_tx_fcs_off
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	logic [4:0] buf_count;
	logic [4:0] next_count;
	logic [BUF_ADDR_W-1:0] wr_ptr;
	logic [BUF_ADDR_W-1:0] rd_ptr;
	logic [2:0] rdy_low_cnt;
	logic buf_wr;
	logic buf_rd;
	logic rd_valid;
	logic tx_violation;
	logic under_cond;
	logic [ENTRY_WIDTH-1:0] wr_entry;
	logic [ENTRY_WIDTH-1:0] rd_entry;
	logic [SEG_COUNT-1:0] rd_ena;
	logic [SEG_COUNT-1:0] rd_sop;
	logic [SEG_COUNT-1:0] rd_eop;
	logic [SEG_COUNT-1:0] rd_err;
	logic [SEG_COUNT-1:0] force_err;
	logic word_open;
	logic word_has_eop;
	spcb_tx_state_type tx_state;
	spcb_tx_state_type next_tx_state;

	// Receive side: register each segment and qualify every flag
	for (genvar s = 0; s < SEG_COUNT; s++) begin : g_rx
		logic last;
		logic bad;
		assign last = mac_rx_ena[s] && mac_rx_eop[s];
		assign bad = last && mac_rx_err[s];
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				rx_data[s] <= '0;
				rx_ena[s] <= 1'b0;
				rx_sop[s] <= 1'b0;
				rx_eop[s] <= 1'b0;
				rx_err[s] <= 1'b0;
				rx_mty[s] <= '0;
			end else if (clk_en) begin
				rx_data[s] <= mac_rx_data[s];
				rx_ena[s] <= mac_rx_ena[s];
				rx_sop[s] <= mac_rx_ena[s] && mac_rx_sop[s];
				rx_eop[s] <= last;
				rx_err[s] <= bad;
				// Empty count only on a last transfer; quiet otherwise
				if (!last) begin
					rx_mty[s] <= '0;
				end else if (bad) begin
					rx_mty[s] <= {mac_rx_mty[s][MTY_WIDTH-1],
						MTY_ERR_LOW};
				end else begin
					rx_mty[s] <= mac_rx_mty[s];
				end
			end
		end

		rx_pass_a: assert property (
			clk_en && mac_rx_ena[s] |=>
			rx_ena[s] && rx_data[s] == $past(mac_rx_data[s]))
			else $error("rx segment not passed through");
		rx_sop_qual_a: assert property (
			clk_en |=> rx_sop[s] == $past(mac_rx_sop[s] && mac_rx_ena[s]))
			else $error("rx sop not qualified by enable");
		rx_mty_qual_a: assert property (
			!(rx_ena[s] && rx_eop[s]) |-> rx_mty[s] == '0)
			else $error("rx empty count outside last transfer");
		rx_mty_err_a: assert property (
			rx_err[s] && rx_ena[s] |->
			rx_mty[s][MTY_LOW_BITS-1:0] == MTY_ERR_LOW)
			else $error("rx empty low bits not cleared on error");
	end

	rx_eop_qual_a: assert property (
		(rx_eop & ~rx_ena) == '0)
		else $error("rx eop without enable");
	rx_err_qual_a: assert property (
		(rx_err & ~(rx_ena & rx_eop)) == '0)
		else $error("rx err without enable and eop");

	// Transmit capture: only enabled cycles, never after an overflow
	assign buf_wr = (|tx_ena) && !tx_ovf && !tx_path_reset &&
		(buf_count != BUF_FULL);
	assign wr_entry = {tx_err, tx_eop, tx_sop, tx_ena,
		tx_data};
	assign buf_rd = mac_tx_accept && (buf_count != 5'h00) && !tx_path_reset;
	assign next_count = buf_count + {4'h0, buf_wr} - {4'h0, buf_rd};

	// Late-window violation or a write into a full buffer both count as overflow
	assign tx_violation = (|tx_ena) && ((!tx_rdy &&
		rdy_low_cnt == TX_RDY_WINDOW) || buf_count == BUF_FULL);

	spcb_buf_mem u_buf (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.wr_en(buf_wr),
		.wr_addr(wr_ptr),
		.wr_data(wr_entry),
		.rd_en(buf_rd),
		.rd_addr(rd_ptr),
		.rd_data(rd_entry)
	);

	// Buffer pointers and fill level; path reset empties the buffer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			buf_count <= 5'h00;
			rd_valid <= 1'b0;
		end else if (clk_en) begin
			if (tx_path_reset) begin
				wr_ptr <= '0;
				rd_ptr <= '0;
				buf_count <= 5'h00;
				rd_valid <= 1'b0;
			end else begin
				wr_ptr <= wr_ptr + BUF_ADDR_W'(buf_wr);
				rd_ptr <= rd_ptr + BUF_ADDR_W'(buf_rd);
				buf_count <= next_count;
				rd_valid <= buf_rd;
			end
		end
	end

	// Ready falls with enough room left for the four-cycle window
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_rdy <= 1'b0;
			rdy_low_cnt <= 3'h0;
		end else if (clk_en) begin
			if (tx_path_reset) begin
				tx_rdy <= 1'b1;
			end else begin
				tx_rdy <= next_count <= BUF_READY_MAX;
			end
			if (tx_rdy) begin
				rdy_low_cnt <= 3'h0;
			end else if (rdy_low_cnt != TX_RDY_WINDOW) begin
				rdy_low_cnt <= rdy_low_cnt + 3'h1;
			end
		end
	end

	// Sticky overflow; a fresh violation wins over the path reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_ovf <= 1'b0;
		end else if (clk_en) begin
			if (tx_violation) begin
				tx_ovf <= 1'b1;
			end else if (tx_path_reset) begin
				tx_ovf <= 1'b0;
			end
		end
	end

	tx_capture_a: assert property (
		clk_en && buf_wr && !buf_rd |=>
		buf_count == $past(buf_count) + 5'h01)
		else $error("enabled transmit word not captured");
	tx_idle_a: assert property (
		tx_ena == '0 |-> !buf_wr)
		else $error("transmit sampled without enable");
	tx_rdy_level_a: assert property (
		$past(reset_n) && $past(clk_en) &&
		!$past(tx_path_reset) |->
		tx_rdy == (buf_count <= BUF_READY_MAX))
		else $error("ready disagrees with buffer fill");
	tx_ovf_set_a: assert property (
		clk_en && (|tx_ena) && !tx_rdy && rdy_low_cnt == TX_RDY_WINDOW
		|=> tx_ovf ##1 (tx_ovf || $past(tx_path_reset && clk_en)))
		else $error("late transfer did not raise overflow");

	// Unpack the word leaving the buffer
	assign rd_ena = rd_entry[ENA_POS +: SEG_COUNT];
	assign rd_sop = rd_entry[SOP_POS +: SEG_COUNT];
	assign rd_eop = rd_entry[EOP_POS +: SEG_COUNT];
	assign rd_err = rd_entry[ERR_POS +: SEG_COUNT];

	// MAC asks for data mid-packet and nothing is on its way
	assign under_cond = mac_tx_accept && buf_count == 5'h00 && !rd_valid &&
		tx_state != SPCB_IDLE;

	// Walk segments from 0 upward to track packet bounds in the word
	always_comb begin
		logic bad_run;
		bad_run = tx_state == SPCB_BAD;
		word_open = tx_state != SPCB_IDLE;
		word_has_eop = 1'b0;
		force_err = '0;
		for (int s = 0; s < SEG_COUNT; s++) begin
			if (rd_ena[s] && rd_sop[s]) begin
				word_open = 1'b1;
				bad_run = 1'b0;
			end
			if (rd_ena[s] && rd_eop[s]) begin
				force_err[s] = rd_err[s] || bad_run;
				word_open = 1'b0;
				word_has_eop = 1'b1;
				bad_run = 1'b0;
			end
		end
	end

	// Packet state: a packet hit by an under-run stays marked bad
	always_comb begin
		next_tx_state = tx_state;
		if (rd_valid) begin
			if (!word_open) begin
				next_tx_state = SPCB_IDLE;
			end else if (word_has_eop || tx_state != SPCB_BAD) begin
				next_tx_state = SPCB_PKT;
			end
		end else if (under_cond) begin
			next_tx_state = SPCB_BAD;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_state <= SPCB_IDLE;
		end else if (clk_en) begin
			if (tx_path_reset) begin
				tx_state <= SPCB_IDLE;
			end else begin
				tx_state <= next_tx_state;
			end
		end
	end

	// Output stage toward the MAC; bad last words carry the error code
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mac_tx_data <= '0;
			mac_tx_ena <= '0;
			mac_tx_sop <= '0;
			mac_tx_eop <= '0;
			mac_tx_fcs_off <= 1'b0;
			mac_tx_err_block <= 1'b0;
			tx_unf <= 1'b0;
		end else if (clk_en) begin
			for (int s = 0; s < SEG_COUNT; s++) begin
				if (force_err[s]) begin
					mac_tx_data[s] <= ERR_CTRL_WORD;
				end else begin
					mac_tx_data[s] <= rd_entry[s*SEG_WIDTH +: SEG_WIDTH];
				end
			end
			mac_tx_ena <= rd_valid ? rd_ena : '0;
			mac_tx_sop <= rd_valid ? (rd_ena & rd_sop) : '0;
			mac_tx_eop <= rd_valid ? (rd_ena & rd_eop) : '0;
			mac_tx_fcs_off <= rd_valid && (|force_err);
			// Level follows the under-run cycle by cycle
			mac_tx_err_block <= under_cond && !tx_path_reset;
			tx_unf <= under_cond && !tx_path_reset;
		end
	end

	sequence tx_err_word;
		clk_en && rd_valid && (|(rd_ena & rd_eop & rd_err));
	endsequence
	sequence tx_err_out;
		mac_tx_fcs_off && (|mac_tx_eop);
	endsequence
	tx_err_code_a: assert property (
		tx_err_word |=> tx_err_out)
		else $error("errored last word not flagged to mac");

	sequence under_run;
		clk_en && under_cond && !tx_path_reset;
	endsequence
	tx_unf_a: assert property (
		under_run |=> tx_unf && tx_state == SPCB_BAD)
		else $error("under-run not reported");
	tx_err_block_a: assert property (
		under_run ##1 under_run |=> mac_tx_err_block [*1] ##0 tx_unf)
		else $error("error blocks stopped during under-run");
endmodule
`default_nettype wire

//--- spcb_user_model.sv
// Purpose: Behavioural user packet source on the transmit side.
// Assumes: Drives at the falling edge; obeys ready unless rogue is set.
// Notes: Released data lines toggle each idle cycle between the last word and its inverse.
`default_nettype none
module spcb_user_model
	import spcb_pkg::*;
(
	input wire logic clk,
	input wire logic tx_rdy,
	input wire logic go,
	input wire logic [4:0] len,
	input wire logic sop_on,
	input wire logic eop_on,
	input wire logic err_on,
	input wire logic rogue,
	input wire logic [SEG_WIDTH-1:0] base,
	output logic [SEG_COUNT-1:0][SEG_WIDTH-1:0] tx_data,
	output logic [SEG_COUNT-1:0] tx_ena,
	output logic [SEG_COUNT-1:0] tx_sop,
	output logic [SEG_COUNT-1:0] tx_eop,
	output logic [SEG_COUNT-1:0] tx_err,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	int sent = 0;
	logic act = 1'b0;
	initial begin
		tx_data = '0;
		{tx_ena, tx_sop, tx_eop, tx_err, busy} = '0;
	end
	// One whole word per cycle; pausing on low ready keeps far inside window
	// Outputs and busy move by NBA, so a caller polling busy on this same
	// falling edge always sees the value from before it, with no race
	always @(negedge clk) begin
		if (go && !act) begin
			act = 1'b1;
			sent = 0;
		end
		if (act && (tx_rdy || rogue)) begin
			tx_ena <= 4'hF;
			tx_sop <= (sent == 0 && sop_on) ? 4'h1 : 4'h0;
			tx_eop <= (sent == len - 1 && eop_on) ? 4'h8 : 4'h0;
			tx_err <= (sent == len - 1 && err_on) ? 4'h8 : 4'h0;
			for (int s = 0; s < SEG_COUNT; s++)
				tx_data[s] <= base + SEG_WIDTH'(sent * 4 + s);
			sent++;
			act = (sent < len);
		end else begin
			tx_ena <= 4'h0;
			tx_data <= ~tx_data;
		end
		busy <= act;
	end
endmodule
`default_nettype wire

//--- spcb_segmented_packet_client_bus_tb.sv
// Purpose: Self-checking bench for the segmented packet client bus.
// Assumes: Queue model predicts every word handed to the MAC side.
// Notes: clk_en drops once after the receive test to check freezing.
`default_nettype none
module spcb_segmented_packet_client_bus_tb
	import spcb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset_n, clk_en, tx_path_reset, tx_rdy, tx_ovf, tx_unf;
	logic mac_tx_accept, mac_tx_err_block, mac_tx_fcs_off;
	logic go, sop_on, eop_on, err_on, rogue, busy, exp_on, bad;
	logic [SEG_COUNT-1:0][SEG_WIDTH-1:0] mac_rx_data, rx_data;
	logic [SEG_COUNT-1:0][SEG_WIDTH-1:0] tx_data, mac_tx_data;
	logic [SEG_COUNT-1:0] mac_rx_ena, mac_rx_sop, mac_rx_eop, mac_rx_err;
	logic [SEG_COUNT-1:0] rx_ena, rx_sop, rx_eop, rx_err;
	logic [SEG_COUNT-1:0] tx_ena, tx_sop, tx_eop, tx_err;
	logic [SEG_COUNT-1:0] mac_tx_ena, mac_tx_sop, mac_tx_eop;
	logic [SEG_COUNT-1:0][MTY_WIDTH-1:0] mac_rx_mty, rx_mty;
	logic [SEG_WIDTH-1:0] base;
	logic [4:0] len;
	logic [524:0] w;
	logic [524:0] expq[$];
	int fails = 0;
	int num_checks = 0;
	int seed = 19304;
	int cyc = 0;

	spcb_segmented_packet_client_bus dut (.clk, .reset_n, .clk_en,
		.mac_rx_data, .mac_rx_ena, .mac_rx_sop, .mac_rx_eop, .mac_rx_err,
		.mac_rx_mty, .rx_data, .rx_ena, .rx_sop, .rx_eop, .rx_err, .rx_mty,
		.tx_data, .tx_ena, .tx_sop, .tx_eop, .tx_err, .tx_path_reset,
		.tx_rdy, .tx_ovf, .tx_unf, .mac_tx_accept, .mac_tx_data,
		.mac_tx_ena, .mac_tx_sop, .mac_tx_eop, .mac_tx_err_block,
		.mac_tx_fcs_off);
	spcb_user_model usr (.clk, .tx_rdy, .go, .len, .sop_on, .eop_on,
		.err_on, .rogue, .base, .tx_data, .tx_ena, .tx_sop, .tx_eop,
		.tx_err, .busy);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input logic [524:0] got, input logic [524:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Hand one packet to the user model and wait, bounded, for it to finish
	task automatic send(input int n, input logic s, e, r);
		base = {$random(seed), $random(seed), $random(seed), $random(seed)};
		len = 5'(n);
		sop_on = s;
		eop_on = e;
		err_on = r;
		go <= 1'b1;
		@(negedge clk);
		go <= 1'b0;
		repeat (40) if (busy || go) @(negedge clk);
	endtask

	// Random receive traffic, every flag checked against its qualifiers
	task automatic rx_test();
		logic [3:0] m;
		for (int i = 0; i < 300; i++) begin
			mac_rx_ena = 4'($random(seed));
			mac_rx_sop = 4'($random(seed));
			mac_rx_eop = 4'($random(seed));
			mac_rx_err = 4'($random(seed));
			mac_rx_mty = 16'($random(seed));
			for (int s = 0; s < SEG_COUNT; s++)
				mac_rx_data[s] = {$random(seed), $random(seed),
					$random(seed), $random(seed)};
			@(negedge clk);
			chk({rx_ena, rx_sop, rx_eop, rx_err}, {mac_rx_ena,
				mac_rx_sop & mac_rx_ena, mac_rx_eop & mac_rx_ena,
				mac_rx_err & mac_rx_ena & mac_rx_eop});
			for (int s = 0; s < SEG_COUNT; s++) begin
				m = mac_rx_mty[s];
				if (mac_rx_err[s])
					m[2:0] = MTY_ERR_LOW;
				if (!(mac_rx_ena[s] && mac_rx_eop[s]))
					m = 4'h0;
				chk(rx_mty[s], m);
				if (mac_rx_ena[s])
					chk(rx_data[s], mac_rx_data[s]);
			end
		end
	endtask

	// A low clock enable must hold every receive flag where it stands
	task automatic freeze_test();
		logic [15:0] held;
		held = {rx_ena, rx_sop, rx_eop, rx_err};
		clk_en = 1'b0;
		mac_rx_ena = ~mac_rx_ena;
		mac_rx_eop = ~mac_rx_eop;
		@(negedge clk);
		chk({rx_ena, rx_sop, rx_eop, rx_err}, held);
		clk_en = 1'b1;
	endtask

	// Reference: predict each word the MAC side should receive
	always @(posedge clk) begin
		if (exp_on && |tx_ena && !tx_ovf && !tx_path_reset) begin
			w = {1'b0, tx_ena, tx_sop, tx_eop, tx_data};
			for (int s = 0; s < SEG_COUNT; s++)
				if (tx_eop[s] && (tx_err[s] || bad)) begin
					w[s*SEG_WIDTH +: SEG_WIDTH] = ERR_CTRL_WORD;
					w[524] = 1'b1;
				end
			if (|tx_eop)
				bad = 1'b0;
			expq.push_back(w);
		end
	end

	// Every MAC-side word must match the head of the prediction
	always @(negedge clk) begin
		if (|mac_tx_ena)
			chk({mac_tx_fcs_off, mac_tx_ena, mac_tx_sop, mac_tx_eop,
				mac_tx_data}, expq.size() ? expq.pop_front() : 'x);
		if (tx_unf === 1'b1)
			bad = 1'b1;
	end

	// Hang guard: the whole run needs only about five hundred cycles
	always @(negedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			fails++;
			print_verdict();
		end
	end

	initial begin
		{reset_n, tx_path_reset, mac_tx_accept, go, rogue, bad} = '0;
		{sop_on, eop_on, err_on} = '0;
		{mac_rx_ena, mac_rx_sop, mac_rx_eop, mac_rx_err, mac_rx_mty} = '0;
		mac_rx_data = '0;
		base = '0;
		len = 5'h01;
		clk_en = 1'b1;
		exp_on = 1'b1;
		repeat (12) @(negedge clk);
		reset_n = 1'b1;
		repeat (2) @(negedge clk);
		chk(tx_rdy, 1'b1);
		rx_test();
		freeze_test();
		$display("test receive done");
		mac_tx_accept = 1'b1;
		send(3, 1'b1, 1'b1, 1'b0);
		send(2, 1'b1, 1'b1, 1'b1);
		repeat (8) @(negedge clk);
		chk(expq.size() == 0, 1'b1);
		$display("test pass-through done");
		mac_tx_accept = 1'b0;
		send(14, 1'b1, 1'b1, 1'b0);
		chk({tx_rdy, tx_ovf}, 2'b00);
		mac_tx_accept = 1'b1;
		repeat (40) @(negedge clk);
		chk({tx_rdy, tx_ovf, expq.size() == 0}, 3'b101);
		$display("test back-pressure done");
		exp_on = 1'b0;
		mac_tx_accept = 1'b0;
		rogue = 1'b1;
		send(20, 1'b1, 1'b1, 1'b0);
		chk(tx_ovf, 1'b1);
		rogue = 1'b0;
		tx_path_reset = 1'b1;
		@(negedge clk);
		tx_path_reset = 1'b0;
		@(negedge clk);
		chk({tx_ovf, tx_rdy}, 2'b01);
		exp_on = 1'b1;
		$display("test overflow done");
		mac_tx_accept = 1'b1;
		send(1, 1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 10 && tx_unf !== 1'b1; i++)
			@(negedge clk);
		chk({tx_unf, mac_tx_err_block}, 2'b11);
		@(negedge clk);
		chk({tx_unf, mac_tx_err_block}, 2'b11);
		mac_tx_accept = 1'b0;
		send(2, 1'b0, 1'b1, 1'b0);
		mac_tx_accept = 1'b1;
		repeat (10) @(negedge clk);
		chk(expq.size() == 0, 1'b1);
		$display("test underflow done");
		print_verdict();
	end
endmodule
`default_nettype wire
